// File: core/pmsm_seq_pkg.sv
package pmsm_seq_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CALCFG = 8'h04;
  localparam logic [7:0] ADR_ALPER = 8'h08;
  localparam logic [7:0] ADR_ALAMP = 8'h0C;
  localparam logic [7:0] ADR_SLOWDIV = 8'h10;
  localparam logic [7:0] ADR_THRESH = 8'h14;
  localparam logic [7:0] ADR_OLSTEP = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1C;
  localparam logic [7:0] ADR_OFFSET = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_ENC = 2;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_FCLR = 8;
  localparam int STAT_EVENT_LO = 4;
  localparam int STAT_POS_LO = 8;
  localparam int STAT_FAULT = 12;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CALLOG_RST = 4'hA;
  localparam logic [15:0] ALPER_RST = 16'h1000;
  localparam logic [15:0] ALAMP_RST = 16'h0800;
  localparam logic [7:0] SLOWDIV_RST = 8'h0A;
  localparam logic [15:0] TRACK_THR_RST = 16'h0200;
  localparam logic [15:0] SENS_THR_RST = 16'h0400;
  localparam logic [15:0] OLSTEP_RST = 16'h0010;

  // ----------------------------------------------------------------
  // sequencer states, position sources and event codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_INIT, ST_FAULT, ST_READY, ST_CALIB, ST_ALIGN, ST_RUN} state_e;
  typedef enum logic [1:0] {POS_FORCED, POS_TRACKING, POS_SENSORLESS, POS_ENCODER} posMode_e;

  localparam logic [3:0] EV_FAULT = 4'h0;
  localparam logic [3:0] EV_FAULT_CLEAR = 4'h1;
  localparam logic [3:0] EV_INIT = 4'h2;
  localparam logic [3:0] EV_INIT_DONE = 4'h3;
  localparam logic [3:0] EV_READY = 4'h4;
  localparam logic [3:0] EV_APP_ON = 4'h5;
  localparam logic [3:0] EV_CALIB = 4'h6;
  localparam logic [3:0] EV_CALIB_DONE = 4'h7;
  localparam logic [3:0] EV_ALIGN = 4'h8;
  localparam logic [3:0] EV_ALIGN_DONE = 4'h9;
  localparam logic [3:0] EV_RUN = 4'hA;
  localparam logic [3:0] EV_APP_OFF = 4'hB;

endpackage

// File: core/pmsm_drive_state_sequencer.sv
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps

module pmsm_drive_state_sequencer #(
  parameter int CUR_W = 12,
  parameter bit ENCODER_PRESENT = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // user pins and fault pin
  input wire logic firstUserButton,
  input wire logic secondUserButton,
  input wire logic faultPin,
  // current converters
  input wire logic convEoc,
  input wire logic [CUR_W-1:0] convCurA,
  input wire logic [CUR_W-1:0] convCurB,
  // observer and encoder
  input wire logic [15:0] estAngle,
  input wire logic [15:0] estSpeed,
  input wire logic [15:0] encAngle,
  // power stage
  output logic pwmEnable,
  output logic pwmHalfDuty,
  output logic alignActive,
  output logic [15:0] dAxisVoltage,
  // control loop side
  output logic [15:0] curACorr,
  output logic [15:0] curBCorr,
  output logic [15:0] ctrlAngle,
  output logic [15:0] observerAngle,
  output logic observerSeedLoad,
  output logic [1:0] posMode,
  output logic fastLoopStrobe,
  output logic slowLoopStrobe,
  output logic [2:0] seqState,
  output logic [3:0] seqEvent
);

  localparam int ACC_W = CUR_W + 16;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pinMeta_q, pinSync_q;
  logic runPrev_q, btnPrev_q;

  // two flops per pin; only the second stage is read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_q <= 3'h0;
      pinSync_q <= 3'h0;
    end else begin
      pinMeta_q <= {faultPin, secondUserButton, firstUserButton};
      pinSync_q <= pinMeta_q;
    end
  end

  wire faultNow = pinSync_q[2];
  wire anyButton = pinSync_q[0] | pinSync_q[1];
  wire bothButtons = pinSync_q[0] & pinSync_q[1];

  // ----------------------------------------------------------------
  // wishbone slave and registers
  // ----------------------------------------------------------------
  logic ack_q;
  logic [31:0] ctrl_q, calCfg_q, alPer_q, alAmp_q, slowDiv_q, thresh_q, olStep_q;
  logic [31:0] rdData_q;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  wire busReq = cyc_i & stb_i;
  wire ack_d = busReq & ~ack_q;
  wire wrNow = busReq & we_i & ack_q;
  wire wrCtrl = wrNow & (adr_i == pmsm_seq_pkg::ADR_CTRL);
  wire faultClearCmd = wrCtrl & sel_i[1] & dat_i[pmsm_seq_pkg::CTRL_FCLR];

  pmsm_seq_pkg::state_e state_q, state_d;
  logic [3:0] event_q, event_d;
  pmsm_seq_pkg::posMode_e posMode_q, posMode_d;
  logic [15:0] offsetA_q, offsetB_q;

  // read mux, unmapped addresses read zero
  wire [31:0] statusWord = {19'h0, faultNow, 2'h0, posMode_q, event_q, 1'b0, state_q};
  wire [31:0] rdData_d =
    (adr_i == pmsm_seq_pkg::ADR_CTRL) ? ctrl_q :
    (adr_i == pmsm_seq_pkg::ADR_CALCFG) ? calCfg_q :
    (adr_i == pmsm_seq_pkg::ADR_ALPER) ? alPer_q :
    (adr_i == pmsm_seq_pkg::ADR_ALAMP) ? alAmp_q :
    (adr_i == pmsm_seq_pkg::ADR_SLOWDIV) ? slowDiv_q :
    (adr_i == pmsm_seq_pkg::ADR_THRESH) ? thresh_q :
    (adr_i == pmsm_seq_pkg::ADR_OLSTEP) ? olStep_q :
    (adr_i == pmsm_seq_pkg::ADR_STATUS) ? statusWord :
    (adr_i == pmsm_seq_pkg::ADR_OFFSET) ? {offsetB_q, offsetA_q} : 32'h0;

  // ack one cycle after the request, write at the acked edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rdData_q <= 32'h0;
      ctrl_q <= 32'h0;
      calCfg_q <= {28'h0, pmsm_seq_pkg::CALLOG_RST};
      alPer_q <= {16'h0, pmsm_seq_pkg::ALPER_RST};
      alAmp_q <= {16'h0, pmsm_seq_pkg::ALAMP_RST};
      slowDiv_q <= {24'h0, pmsm_seq_pkg::SLOWDIV_RST};
      thresh_q <= {pmsm_seq_pkg::SENS_THR_RST, pmsm_seq_pkg::TRACK_THR_RST};
      olStep_q <= {16'h0, pmsm_seq_pkg::OLSTEP_RST};
    end else begin
      ack_q <= ack_d;
      if (ack_d) begin
        rdData_q <= rdData_d;
      end
      if (wrCtrl) begin
        ctrl_q <= mergeBytes(ctrl_q, dat_i, sel_i) & 32'h0000_0037;
      end
      if (wrNow && adr_i == pmsm_seq_pkg::ADR_CALCFG) begin
        calCfg_q <= mergeBytes(calCfg_q, dat_i, sel_i) & 32'h0000_000F;
      end
      if (wrNow && adr_i == pmsm_seq_pkg::ADR_ALPER) begin
        alPer_q <= mergeBytes(alPer_q, dat_i, sel_i) & 32'h0000_FFFF;
      end
      if (wrNow && adr_i == pmsm_seq_pkg::ADR_ALAMP) begin
        alAmp_q <= mergeBytes(alAmp_q, dat_i, sel_i) & 32'h0000_FFFF;
      end
      if (wrNow && adr_i == pmsm_seq_pkg::ADR_SLOWDIV) begin
        slowDiv_q <= mergeBytes(slowDiv_q, dat_i, sel_i) & 32'h0000_00FF;
      end
      if (wrNow && adr_i == pmsm_seq_pkg::ADR_THRESH) begin
        thresh_q <= mergeBytes(thresh_q, dat_i, sel_i);
      end
      if (wrNow && adr_i == pmsm_seq_pkg::ADR_OLSTEP) begin
        olStep_q <= mergeBytes(olStep_q, dat_i, sel_i) & 32'h0000_FFFF;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdData_q;

  // ----------------------------------------------------------------
  // working configuration, latched in the initialise pass
  // ----------------------------------------------------------------
  logic [3:0] calLog_q;
  logic [15:0] alPreset_q, alAmpW_q;
  logic [7:0] slowN_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      calLog_q <= pmsm_seq_pkg::CALLOG_RST;
      alPreset_q <= pmsm_seq_pkg::ALPER_RST;
      alAmpW_q <= pmsm_seq_pkg::ALAMP_RST;
      slowN_q <= pmsm_seq_pkg::SLOWDIV_RST;
    end else if (state_q == pmsm_seq_pkg::ST_INIT) begin
      calLog_q <= calCfg_q[3:0];
      alPreset_q <= alPer_q[15:0];
      alAmpW_q <= alAmp_q[15:0];
      slowN_q <= slowDiv_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // calibration and alignment counters
  // ----------------------------------------------------------------
  logic [15:0] calCnt_q, alCnt_q;
  logic [ACC_W-1:0] accA_q, accB_q;
  wire [ACC_W-1:0] sumA = accA_q + {{16{1'b0}}, convCurA};
  wire [ACC_W-1:0] sumB = accB_q + {{16{1'b0}}, convCurB};
  wire [15:0] calLast = 16'((17'h1 << calLog_q) - 17'h1);
  wire inCalib = state_q == pmsm_seq_pkg::ST_CALIB;
  wire inAlign = state_q == pmsm_seq_pkg::ST_ALIGN;
  wire inRun = state_q == pmsm_seq_pkg::ST_RUN;
  wire calDone = inCalib & convEoc & (calCnt_q == calLast);
  wire alignDone = inAlign & convEoc & (alCnt_q == 16'h0);

  // stop and start commands
  wire runReq = ctrl_q[pmsm_seq_pkg::CTRL_RUN];
  wire runFall = runPrev_q & ~runReq;
  wire appOff = runFall | (inRun & bothButtons);
  wire startCmd = (anyButton & ~btnPrev_q) | runReq;

  // ----------------------------------------------------------------
  // sequencer next state; fault, then stop, then completion
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    event_d = event_q;
    case (state_q)
      pmsm_seq_pkg::ST_INIT: begin
        state_d = pmsm_seq_pkg::ST_READY;
        event_d = pmsm_seq_pkg::EV_INIT_DONE;
      end
      pmsm_seq_pkg::ST_FAULT: begin
        if (faultClearCmd && !faultNow) begin
          state_d = pmsm_seq_pkg::ST_INIT;
          event_d = pmsm_seq_pkg::EV_FAULT_CLEAR;
        end
      end
      pmsm_seq_pkg::ST_READY: begin
        event_d = pmsm_seq_pkg::EV_READY;
        if (startCmd) begin
          state_d = pmsm_seq_pkg::ST_CALIB;
          event_d = pmsm_seq_pkg::EV_APP_ON;
        end
      end
      pmsm_seq_pkg::ST_CALIB: begin
        event_d = pmsm_seq_pkg::EV_CALIB;
        if (calDone) begin
          state_d = pmsm_seq_pkg::ST_ALIGN;
          event_d = pmsm_seq_pkg::EV_CALIB_DONE;
        end
      end
      pmsm_seq_pkg::ST_ALIGN: begin
        event_d = pmsm_seq_pkg::EV_ALIGN;
        if (alignDone) begin
          state_d = pmsm_seq_pkg::ST_RUN;
          event_d = pmsm_seq_pkg::EV_ALIGN_DONE;
        end
      end
      pmsm_seq_pkg::ST_RUN: begin
        event_d = pmsm_seq_pkg::EV_RUN;
      end
      default: begin
        state_d = pmsm_seq_pkg::ST_INIT;
        event_d = pmsm_seq_pkg::EV_INIT;
      end
    endcase
    // stop overrides completion; never from ready
    if ((inCalib || inAlign || inRun) && appOff) begin
      state_d = pmsm_seq_pkg::ST_INIT;
      event_d = pmsm_seq_pkg::EV_APP_OFF;
    end
    // fault overrides everything
    if (faultNow && state_q != pmsm_seq_pkg::ST_FAULT) begin
      state_d = pmsm_seq_pkg::ST_FAULT;
      event_d = pmsm_seq_pkg::EV_FAULT;
    end
  end

  // state, event and power stage registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= pmsm_seq_pkg::ST_INIT;
      event_q <= pmsm_seq_pkg::EV_INIT;
      runPrev_q <= 1'b0;
      btnPrev_q <= 1'b0;
      pwmEnable <= 1'b0;
      pwmHalfDuty <= 1'b0;
      alignActive <= 1'b0;
      dAxisVoltage <= 16'h0;
    end else begin
      state_q <= state_d;
      event_q <= event_d;
      runPrev_q <= runReq;
      btnPrev_q <= anyButton;
      pwmEnable <= state_d == pmsm_seq_pkg::ST_CALIB || state_d == pmsm_seq_pkg::ST_ALIGN ||
                   state_d == pmsm_seq_pkg::ST_RUN;
      pwmHalfDuty <= state_d == pmsm_seq_pkg::ST_CALIB;
      alignActive <= state_d == pmsm_seq_pkg::ST_ALIGN;
      dAxisVoltage <= (state_d == pmsm_seq_pkg::ST_ALIGN) ? alAmpW_q : 16'h0;
    end
  end

  // sample accumulation, offsets and alignment timer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      calCnt_q <= 16'h0;
      accA_q <= '0;
      accB_q <= '0;
      offsetA_q <= 16'h0;
      offsetB_q <= 16'h0;
      alCnt_q <= pmsm_seq_pkg::ALPER_RST;
    end else if (state_q == pmsm_seq_pkg::ST_INIT) begin
      calCnt_q <= 16'h0;
      accA_q <= '0;
      accB_q <= '0;
      offsetA_q <= 16'h0;
      offsetB_q <= 16'h0;
      alCnt_q <= alPer_q[15:0];
    end else if (inCalib && convEoc) begin
      calCnt_q <= calCnt_q + 16'h1;
      accA_q <= sumA;
      accB_q <= sumB;
      if (calDone) begin
        offsetA_q <= 16'(sumA >> calLog_q);
        offsetB_q <= 16'(sumB >> calLog_q);
      end
    end else if (inAlign && convEoc) begin
      alCnt_q <= alignDone ? alPreset_q : alCnt_q - 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // position source selection
  // ----------------------------------------------------------------
  wire autoMode = ctrl_q[pmsm_seq_pkg::CTRL_AUTO];
  wire encFeedback = ctrl_q[pmsm_seq_pkg::CTRL_ENC] & ENCODER_PRESENT;
  wire [1:0] manualMode = ctrl_q[pmsm_seq_pkg::CTRL_MODE_LO +: 2];
  wire [15:0] speedMag = estSpeed[15] ? 16'(~estSpeed + 16'h1) : estSpeed;

  always_comb begin
    posMode_d = pmsm_seq_pkg::POS_FORCED;
    if (inRun) begin
      if (encFeedback) begin
        posMode_d = pmsm_seq_pkg::POS_ENCODER;
      end else if (autoMode) begin
        if (speedMag < thresh_q[15:0]) begin
          posMode_d = pmsm_seq_pkg::POS_FORCED;
        end else if (speedMag < thresh_q[31:16]) begin
          posMode_d = pmsm_seq_pkg::POS_TRACKING;
        end else begin
          posMode_d = pmsm_seq_pkg::POS_SENSORLESS;
        end
      end else if (manualMode == 2'(pmsm_seq_pkg::POS_ENCODER)) begin
        posMode_d = pmsm_seq_pkg::POS_SENSORLESS;
      end else begin
        posMode_d = pmsm_seq_pkg::posMode_e'(manualMode);
      end
    end
  end

  // ----------------------------------------------------------------
  // loop scheduling, open-loop angle and corrected currents
  // ----------------------------------------------------------------
  logic [7:0] slowCnt_q;
  logic eocDly_q;
  logic [15:0] olAngle_q, estPrev_q;
  wire slowHit = convEoc & (slowCnt_q == 8'h0);

  // slow strobe on the event edge, fast strobe one cycle later
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slowCnt_q <= pmsm_seq_pkg::SLOWDIV_RST;
      eocDly_q <= 1'b0;
      slowLoopStrobe <= 1'b0;
      fastLoopStrobe <= 1'b0;
    end else begin
      eocDly_q <= convEoc;
      slowLoopStrobe <= slowHit & inRun;
      fastLoopStrobe <= eocDly_q;
      if (state_q == pmsm_seq_pkg::ST_INIT) begin
        slowCnt_q <= slowDiv_q[7:0];
      end else if (convEoc) begin
        slowCnt_q <= slowHit ? slowN_q : slowCnt_q - 8'h1;
      end
    end
  end

  // angle paths and offset-corrected currents
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      olAngle_q <= 16'h0;
      estPrev_q <= 16'h0;
      posMode_q <= pmsm_seq_pkg::POS_FORCED;
      ctrlAngle <= 16'h0;
      observerAngle <= 16'h0;
      observerSeedLoad <= 1'b0;
      curACorr <= 16'h0;
      curBCorr <= 16'h0;
    end else begin
      posMode_q <= posMode_d;
      if (alignDone || state_q == pmsm_seq_pkg::ST_INIT) begin
        olAngle_q <= 16'h0;
      end else if (inRun && eocDly_q) begin
        olAngle_q <= olAngle_q + olStep_q[15:0];
      end
      if (eocDly_q) begin
        estPrev_q <= estAngle;
      end
      case (posMode_q)
        pmsm_seq_pkg::POS_FORCED: ctrlAngle <= olAngle_q;
        pmsm_seq_pkg::POS_TRACKING: ctrlAngle <= olAngle_q;
        pmsm_seq_pkg::POS_SENSORLESS: ctrlAngle <= estAngle;
        pmsm_seq_pkg::POS_ENCODER: ctrlAngle <= encAngle;
        default: ctrlAngle <= olAngle_q;
      endcase
      observerSeedLoad <= inRun && posMode_q == pmsm_seq_pkg::POS_FORCED;
      observerAngle <= (posMode_q == pmsm_seq_pkg::POS_FORCED) ? olAngle_q : estPrev_q;
      if (convEoc && !inCalib) begin
        curACorr <= 16'({4'h0, convCurA}) - offsetA_q;
        curBCorr <= 16'({4'h0, convCurB}) - offsetB_q;
      end
    end
  end

  assign posMode = posMode_q;
  assign seqState = state_q;
  assign seqEvent = event_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_init_pass;
    @(posedge ref_clk) disable iff (!nrst)
    (state_q == pmsm_seq_pkg::ST_INIT && !faultNow) |=>
      (state_q == pmsm_seq_pkg::ST_READY && event_q == pmsm_seq_pkg::EV_INIT_DONE);
  endproperty
  a_init_pass: assert property (p_init_pass) else $error("init pass did not reach ready");

  property p_start;
    @(posedge ref_clk) disable iff (!nrst)
    (state_q == pmsm_seq_pkg::ST_READY && startCmd && !faultNow) |=>
      (state_q == pmsm_seq_pkg::ST_CALIB && event_q == pmsm_seq_pkg::EV_APP_ON);
  endproperty
  a_start: assert property (p_start) else $error("start not taken in ready");

  property p_calib_pwm;
    @(posedge ref_clk) disable iff (!nrst)
    (state_q == pmsm_seq_pkg::ST_CALIB) |-> (pwmEnable && pwmHalfDuty && dAxisVoltage == 16'h0);
  endproperty
  a_calib_pwm: assert property (p_calib_pwm) else $error("calibration pwm wrong");

  property p_offset;
    @(posedge ref_clk) disable iff (!nrst)
    (convEoc && inRun) |=> curACorr == 16'({4'h0, $past(convCurA)}) - offsetA_q;
  endproperty
  a_offset: assert property (p_offset) else $error("offset not subtracted");

  property p_calib_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (inCalib && !faultNow && !appOff && !calDone) |=> inCalib;
  endproperty
  a_calib_hold: assert property (p_calib_hold) else $error("calibration left early");

  property p_fault;
    @(posedge ref_clk) disable iff (!nrst)
    ((inCalib || inAlign || inRun) && faultNow) |=> state_q == pmsm_seq_pkg::ST_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not entered");

  property p_app_off;
    @(posedge ref_clk) disable iff (!nrst)
    ((inCalib || inAlign || inRun) && runFall && !faultNow) |=>
      (state_q == pmsm_seq_pkg::ST_INIT && event_q == pmsm_seq_pkg::EV_APP_OFF);
  endproperty
  a_app_off: assert property (p_app_off) else $error("stop did not win");

  property p_align_end;
    @(posedge ref_clk) disable iff (!nrst)
    (alignDone && !appOff && !faultNow) |=>
      (inRun && alCnt_q == alPreset_q && olAngle_q == 16'h0);
  endproperty
  a_align_end: assert property (p_align_end) else $error("alignment end wrong");

  property p_no_encoder;
    @(posedge ref_clk) disable iff (!nrst)
    !ENCODER_PRESENT |-> posMode_q != pmsm_seq_pkg::POS_ENCODER;
  endproperty
  a_no_encoder: assert property (p_no_encoder) else $error("encoder without option");

  property p_slow_first;
    @(posedge ref_clk) disable iff (!nrst)
    slowLoopStrobe |-> ##1 fastLoopStrobe;
  endproperty
  a_slow_first: assert property (p_slow_first) else $error("fast loop not after slow");

  c_calib_done: cover property (@(posedge ref_clk) disable iff (!nrst) calDone);
  c_run: cover property (@(posedge ref_clk) disable iff (!nrst) inRun && slowLoopStrobe);
  c_both_buttons: cover property (@(posedge ref_clk) disable iff (!nrst) inRun && bothButtons);

endmodule

// File: dv/pmsm_stage_model.sv
`timescale 1ns/100ps
module pmsm_stage_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // power stage
  input wire logic pwmHalfDuty,
  // converters
  output logic convEoc,
  output logic [11:0] convCurA,
  output logic [11:0] convCurB
);
  logic [1:0] divQ;
  // end of sequence on every fourth cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      divQ <= 2'h0;
    end else begin
      divQ <= divQ + 2'h1;
    end
  end
  assign convEoc = (divQ == 2'h3);
  // half duty shows the bare offset; off the strobe the samples churn
  assign convCurA = convEoc ? (pwmHalfDuty ? 12'h800 : 12'h805) : {6{divQ}};
  assign convCurB = convEoc ? (pwmHalfDuty ? 12'h7F0 : 12'h7F3) : {6{~divQ}};
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, btnA = 1'b0, btnB = 1'b0, fault = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, datO, rd;
  logic [3:0] sel = 4'h0;
  logic ackO, eoc, pwmEn, half, alAct, seed;
  logic [11:0] curA, curB;
  logic [15:0] dV, corrA, corrB, cA, oA, spd = 16'h0;
  logic slow, fast;
  int nSlow = 0, nFast = 0;
  logic [1:0] pm;
  logic [2:0] st;
  logic [3:0] ev;
  int nFail = 0, nTests = 0;
  localparam logic [7:0] RA [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24};
  localparam logic [31:0] RE [7] = '{32'hA, 32'h1000, 32'h800, 32'hA, 32'h4000200, 32'h10, 32'h0};
  // free-running clock
  always #5 ref_clk = ~ref_clk;
  pmsm_stage_model i_pmsm_stage_model (.ref_clk(ref_clk), .nrst(nrst), .pwmHalfDuty(half),
    .convEoc(eoc), .convCurA(curA), .convCurB(curB));
  pmsm_drive_state_sequencer i_pmsm_drive_state_sequencer (.ref_clk(ref_clk), .nrst(nrst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(datO),
    .ack_o(ackO), .firstUserButton(btnA), .secondUserButton(btnB), .faultPin(fault),
    .convEoc(eoc), .convCurA(curA), .convCurB(curB), .estAngle(16'h0), .estSpeed(spd),
    .encAngle(16'h0), .pwmEnable(pwmEn), .pwmHalfDuty(half), .alignActive(alAct),
    .dAxisVoltage(dV), .curACorr(corrA), .curBCorr(corrB), .ctrlAngle(cA), .observerAngle(oA),
    .observerSeedLoad(seed), .posMode(pm), .fastLoopStrobe(fast), .slowLoopStrobe(slow),
    .seqState(st), .seqEvent(ev));
  // counts and ends the run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e) begin
      nFail++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // single classic bus cycle, ack taken at the rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    for (k = 0; k < 20 && ackO !== 1'b1; k++) @(posedge ref_clk);
    rd = datO;
    {cyc, stb} <= 2'b00;
    check(32'(ackO), 32'h1);
    if (ackO !== 1'b1) print_verdict();
  endtask
  // bounded wait for a sequencer state
  task automatic waitSt(input logic [2:0] s);
    int k;
    for (k = 0; k < 500 && st !== s; k++) @(negedge ref_clk);
    check(32'(st), 32'(s));
    if (st !== s) print_verdict();
  endtask
  // reset, register rows, then the full start-up and stop paths
  initial begin
    repeat (5) @(posedge ref_clk);
    check(32'({pwmEn, st, ev}), 32'h02);
    nrst <= 1'b1;
    repeat (2) @(negedge ref_clk);
    check(32'(st), 32'h2);
    check(32'(ev), 32'h3);
    foreach (RA[i]) begin
      wb(1'b0, RA[i], 32'h0);
      check(rd, RE[i]);
    end
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b1, 8'h08, 32'h2);
    wb(1'b1, 8'h0C, 32'h123);
    wb(1'b1, 8'h00, 32'h1);
    waitSt(3'h3);
    check(32'({pwmEn, half}), 32'h3);
    wb(1'b1, 8'h00, 32'h0);
    waitSt(3'h2);
    @(posedge ref_clk);
    btnA <= 1'b1;
    waitSt(3'h3);
    @(posedge ref_clk);
    btnA <= 1'b0;
    waitSt(3'h4);
    repeat (2) @(negedge ref_clk);
    check(32'({alAct, dV}), 32'h10123);
    check(32'(ev), 32'h8);
    wb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h07F00800);
    waitSt(3'h5);
    repeat (8) @(negedge ref_clk);
    check({corrA, corrB}, 32'h00050003);
    check(32'({pm, seed}), 32'h1);
    check(32'(cA), 32'(oA));
    // eoc every 4 cycles, slow divider 10: 22 fast and 2 slow in 88 cycles
    for (int k = 0; k < 88; k++) begin
      @(negedge ref_clk);
      nSlow += slow;
      nFast += fast;
    end
    check(nSlow, 32'h2);
    check(nFast, 32'h16);
    wb(1'b1, 8'h00, 32'h30);
    repeat (4) @(negedge ref_clk);
    check(32'({pm, cA}), 32'h20000);
    @(posedge ref_clk);
    spd <= 16'h0300;
    wb(1'b1, 8'h00, 32'h2);
    repeat (4) @(negedge ref_clk);
    check(32'(pm), 32'h1);
    @(posedge ref_clk);
    spd <= 16'hFB00;
    repeat (4) @(negedge ref_clk);
    check(32'(pm), 32'h2);
    @(posedge ref_clk);
    {btnA, btnB} <= 2'b11;
    waitSt(3'h2);
    @(posedge ref_clk);
    {btnA, btnB} <= 2'b00;
    wb(1'b1, 8'h00, 32'h1);
    @(posedge ref_clk);
    fault <= 1'b1;
    waitSt(3'h1);
    @(posedge ref_clk);
    fault <= 1'b0;
    wb(1'b1, 8'h00, 32'h100);
    waitSt(3'h2);
    print_verdict();
  end
endmodule
